// [hdl/sbin_binner.sv]
// sort code bin counter: counts codes per channel between strobes, emits packed counter words
// assumes input words come at most one per cycle and the consumer never stalls
// Function
// - strobe latches all counters then clears them
// - strobe from internal timer or external trigger
// - count each tracked code per channel
// - input words carry four channel codes
// - code count and counter width configurable
// - latched counters go out as 32-bit words
// - channel major, code one below two
// - k-bit counter spans zero to 2^k-1
// - consumer unpacks by channel, code, field
// - sorter output delay is width plus two
// - artifact rejection adds one more width
// - sorter drops snippets above rejection level
// - at most five sort classes per channel
// - auto threshold follows five second RMS
// - codes zero and thirty-one never counted
`timescale 1ns/1ps
module sbin_binner
    import sbin_pkg::*;
#(
    parameter int NUM_CH       = SBIN_NUM_CH,
    parameter int CODES        = SBIN_CODES,
    parameter int CNT_W        = SBIN_CNT_W,
    parameter int TIMER_CYCLES = SBIN_TIMER_CYCLES
) (
    // link
    sbin_if.binner             lnk,
    // control port
    input  wire logic [7:0]    usr_addr,
    input  wire logic [31:0]   usr_wdata,
    input  wire logic          usr_wr,
    input  wire logic          usr_rd,
    output logic [31:0]        usr_rdata,
    // status
    output logic               strobe_pulse
);
    // ************************************************************
    // sizes
    // ************************************************************
    localparam int CW   = NUM_CH * CODES * CNT_W;                        // all counters
    localparam int NOUT = (CW + SBIN_WORD_W - 1) / SBIN_WORD_W;          // words per frame
    localparam int LW   = NOUT * SBIN_WORD_W;                            // padded frame
    // pad bits above the last counter are never written and go out as zeros
    // frame width follows the configured channels, codes and counter width

    // all state in one packed struct: the comb block fills d, the flop block
    // registers it, so no field can be missed by the reset
    typedef struct packed {
        logic [CW-1:0]          cnt;     // running counters
        logic [LW-1:0]          lat;     // latched frame
        sbin_emit_e             st;      // output sequencer
        logic [SBIN_IDX_W-1:0]  widx;    // next word to send
        logic [31:0]            tmr;     // internal period timer
        logic                   trig_p;  // trigger level last cycle
        logic [1:0]             ctrl;    // source and run bits
        logic [15:0]            nstrobe; // strobes since reset
        logic [31:0]            rdata;   // read answer
        logic                   stb;     // strobe happened
        logic                   ov;      // word out valid
        logic [SBIN_IDX_W-1:0]  oidx;    // word out index
        logic [SBIN_WORD_W-1:0] oword;   // word out data
        logic                   olast;   // last word of frame
    } sbin_bin_state_s;

    sbin_bin_state_s q;                  // registered state
    sbin_bin_state_s d;                  // next state

    // ************************************************************
    // next state
    // ************************************************************
    // the sorter's delay, rejection and thresholding only shift when codes
    // arrive; counting does not depend on them
    always_comb begin
        logic             tick;
        logic             strobe;
        logic [7:0]       code;
        logic [CNT_W-1:0] f;
        int               ch;
        int               off;
        tick   = 1'b0;
        strobe = 1'b0;
        code   = '0;
        f      = '0;
        ch     = 0;
        off    = 0;
        // every field holds unless a branch below changes it; the word pulse,
        // the last flag and the read answer fall back to zero each cycle
        d      = q;
        d.ov     = 1'b0;
        d.olast  = 1'b0;
        d.rdata  = '0;
        d.trig_p = lnk.external_latch_trigger_input;

        // internal timer runs only while enabled on the timer source
        // limitation: it restarts from zero on any change of source or run,
        // so the first interval after a switch is always a full period
        if (!q.ctrl[SBIN_CTRL_RUN_BIT] || q.ctrl[SBIN_CTRL_SRC_BIT]) begin
            d.tmr = '0;
        end else if (q.tmr >= 32'(TIMER_CYCLES - 1)) begin
            d.tmr = '0;
            tick  = 1'b1;
        end else begin
            d.tmr = q.tmr + 32'h1;
        end

        // strobe source select: timer wrap or rising trigger edge
        // edge taken from the live input against the registered level: no added latency, and a
        // trigger held high gives exactly one strobe
        if (q.ctrl[SBIN_CTRL_RUN_BIT]) begin
            if (q.ctrl[SBIN_CTRL_SRC_BIT]) begin
                strobe = lnk.external_latch_trigger_input && !q.trig_p;
            end else begin
                strobe = tick;
            end
        end
        d.stb = strobe;

        // latch the pre-strobe counts and clear; a code in the strobe cycle
        // counts into the fresh interval so nothing is lost
        if (strobe) begin
            d.lat     = LW'(q.cnt);
            d.cnt     = '0;
            d.st      = SBIN_EMIT;
            d.widx    = '0;
            d.nstrobe = q.nstrobe + 16'h1;
        end

        // four lanes per input word, channel = word index * 4 + lane
        // saturating instead of wrapping keeps a busy channel from reading as quiet
        if (lnk.code_valid) begin
            for (int l = 0; l < SBIN_LANES; l++) begin
                ch   = int'(lnk.code_idx) * SBIN_LANES + l;
                code = lnk.code_word[l*SBIN_CODE_W +: SBIN_CODE_W];
                // zero, outlier and untracked codes fall outside 1..CODES
                if (ch < NUM_CH && code != SBIN_CODE_UNSORTED && code != SBIN_CODE_OUTLIER
                    && int'(code) <= CODES) begin
                    off = (ch * CODES + int'(code) - 1) * CNT_W;
                    f   = d.cnt[off +: CNT_W];
                    if (f != {CNT_W{1'b1}}) begin
                        d.cnt[off +: CNT_W] = f + 1'b1;
                    end
                end
            end
        end

        // frame sequencer: one word a cycle; a new strobe restarts the frame
        // hazard: the consumer cannot stall, so words leave back to back; a strobe
        // in mid-frame drops the rest of the old frame and no last flag marks it
        unique case (q.st)
            SBIN_IDLE: begin
                // waiting for a strobe
            end
            SBIN_EMIT: begin
                if (!strobe) begin
                    d.ov    = 1'b1;
                    d.oidx  = q.widx;
                    d.oword = q.lat[int'(q.widx)*SBIN_WORD_W +: SBIN_WORD_W];
                    d.olast = (int'(q.widx) == NOUT - 1);
                    d.widx  = SBIN_IDX_W'(q.widx + 1'b1);
                    if (int'(q.widx) == NOUT - 1) begin
                        d.st = SBIN_IDLE;
                    end
                end
            end
        endcase

        // control port: write takes effect next cycle, read answers next cycle
        // only the two low bits of a ctrl write are kept; offsets other than ctrl and status read as zero
        if (usr_wr && usr_addr == SBIN_REG_CTRL) begin
            d.ctrl = usr_wdata[1:0];
        end
        if (usr_rd) begin
            if (usr_addr == SBIN_REG_CTRL) begin
                d.rdata = {30'h0, q.ctrl};
            end else if (usr_addr == SBIN_REG_STATUS) begin
                d.rdata = {15'h0, (q.st == SBIN_EMIT), q.nstrobe};
            end else begin
                d.rdata = '0;                                              // unmapped
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    // synchronous reset; ctrl comes up running on the internal timer so the
    // block produces frames even before software touches it
    always_ff @(posedge lnk.core_clk) begin
        if (!lnk.rst_n) begin
            // clear everything, then overlay the control reset value
            q      <= '0;
            q.ctrl <= SBIN_CTRL_RST;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // every output comes straight from a flop, so no comb path reaches the partner
    assign lnk.out_valid = q.ov;
    assign lnk.out_idx   = q.oidx;
    assign lnk.out_word  = q.oword;
    assign lnk.out_last  = q.olast;
    assign usr_rdata     = q.rdata;
    assign strobe_pulse  = q.stb;
endmodule

// [pkg/sbin_pkg.sv]
// shared constants and types of the sort code bin counter and its upstream/downstream end
// assumes one 100 MHz sample clock for both ends and a synchronous active-low reset
package sbin_pkg;

    // ************************************************************
    // clock and strobe timer
    // ************************************************************
    localparam int SBIN_CLK_PERIOD_NS    = 10;            // core_clk period
    localparam int SBIN_TIMER_PERIOD_MS  = 100;           // internal strobe period
    localparam int SBIN_TIMER_CYCLES     = (SBIN_TIMER_PERIOD_MS * 1000000) / SBIN_CLK_PERIOD_NS;

    // ************************************************************
    // stream layout
    // ************************************************************
    localparam int SBIN_WORD_W           = 32;            // output and input word width
    localparam int SBIN_LANES            = 4;             // channels per input word
    localparam int SBIN_CODE_W           = 8;             // one channel's code inside a word
    localparam int SBIN_IDX_W            = 8;             // word index width
    localparam int SBIN_NUM_CH           = 16;            // default channel count
    localparam int SBIN_CODES            = 2;             // default tracked codes per channel
    localparam int SBIN_CNT_W            = 4;             // default counter width
    localparam int SBIN_MAX_SORTS        = 5;             // highest code the sorter may emit

    // ************************************************************
    // special codes
    // ************************************************************
    localparam logic [7:0] SBIN_CODE_UNSORTED = 8'h00;    // never counted
    localparam logic [7:0] SBIN_CODE_OUTLIER  = 8'h1F;    // never counted

    // ************************************************************
    // control registers on the user port
    // ************************************************************
    localparam logic [7:0] SBIN_REG_CTRL     = 8'h00;     // bit0 source, bit1 run
    localparam logic [7:0] SBIN_REG_STATUS   = 8'h04;     // strobe count, emitting flag
    localparam int         SBIN_CTRL_SRC_BIT = 0;         // 1 selects the external trigger
    localparam int         SBIN_CTRL_RUN_BIT = 1;         // 1 lets strobes happen
    localparam logic [1:0] SBIN_CTRL_RST     = 2'h2;      // running, internal timer
    localparam int         SBIN_STAT_EMIT_BIT = 16;       // output words still going out

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic {SBIN_IDLE, SBIN_EMIT} sbin_emit_e;

endpackage

// [pkg/sbin_if.sv]
// carrier between the bin counter and its stream partner
// assumes the testbench supplies core_clk and rst_n
`timescale 1ns/1ps
interface sbin_if
    import sbin_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n
);
    // packed sort code words, four channels each
    logic                   code_valid;
    logic [SBIN_IDX_W-1:0]  code_idx;
    logic [SBIN_WORD_W-1:0] code_word;
    // logic level trigger from another block
    logic                   external_latch_trigger_input;
    // packed counter words
    logic                   out_valid;
    logic [SBIN_IDX_W-1:0]  out_idx;
    logic [SBIN_WORD_W-1:0] out_word;
    logic                   out_last;

    // the bin counter
    modport binner (
        input  core_clk, rst_n,
        input  code_valid, code_idx, code_word, external_latch_trigger_input,
        output out_valid, out_idx, out_word, out_last
    );

    // the sorter and consumer end
    modport partner (
        input  core_clk, rst_n,
        output code_valid, code_idx, code_word, external_latch_trigger_input,
        input  out_valid, out_idx, out_word, out_last
    );
endinterface

// [hdl/sbin_partner.sv]
// partner end: packs per-channel sort codes four to a word and unpacks counter words
// assumes channels arrive in ascending order, one per cycle, last one flagged
`timescale 1ns/1ps
module sbin_partner
    import sbin_pkg::*;
#(
    parameter int NUM_CH = SBIN_NUM_CH,
    parameter int CODES  = SBIN_CODES,
    parameter int CNT_W  = SBIN_CNT_W
) (
    // link
    sbin_if.partner            lnk,
    // sort code feed
    input  wire logic          ch_valid,
    input  wire logic [7:0]    ch_code,
    input  wire logic          ch_last,
    input  wire logic          trig_in,
    // counter readback
    input  wire logic [7:0]    sel_ch,
    input  wire logic [2:0]    sel_code,
    output logic [CNT_W-1:0]   sel_count,
    output logic               frame_done
);
    // ************************************************************
    // state
    // ************************************************************
    localparam int NOUT = (NUM_CH * CODES * CNT_W + SBIN_WORD_W - 1) / SBIN_WORD_W;
    localparam int LW   = NOUT * SBIN_WORD_W;

    typedef struct packed {
        logic [SBIN_WORD_W-1:0] pack;   // word being filled
        logic [1:0]             lane;   // next free lane
        logic [SBIN_IDX_W-1:0]  widx;   // index of word being filled
        logic                   cv;     // word out valid
        logic [SBIN_IDX_W-1:0]  cidx;   // word out index
        logic [SBIN_WORD_W-1:0] cword;  // word out data
        logic                   trig;   // registered trigger level
        logic [LW-1:0]          rx;     // last received counter frame
        logic [CNT_W-1:0]       cnt;    // selected counter
        logic                   done;   // frame complete pulse
    } sbin_part_state_s;

    sbin_part_state_s q;                // registered state
    sbin_part_state_s d;                // next state

    // ************************************************************
    // next state
    // ************************************************************
    // codes above the hardware sort limit are folded into the outlier code
    always_comb begin
        logic [7:0] code;
        int         off;
        code = ch_code;
        off  = 0;
        d    = q;
        d.cv   = 1'b0;
        d.done = 1'b0;
        d.trig = trig_in;
        if (ch_code > 8'(SBIN_MAX_SORTS) && ch_code != SBIN_CODE_OUTLIER) begin
            code = SBIN_CODE_OUTLIER;
        end
        if (ch_valid) begin
            d.pack[int'(q.lane)*SBIN_CODE_W +: SBIN_CODE_W] = code;
            if (q.lane == 2'h3 || ch_last) begin
                // unused lanes stay unsorted and are never counted
                d.cv    = 1'b1;
                d.cidx  = q.widx;
                d.cword = d.pack;
                d.pack  = '0;
                d.lane  = 2'h0;
                d.widx  = ch_last ? '0 : SBIN_IDX_W'(q.widx + 1'b1);
            end else begin
                d.lane  = 2'(q.lane + 1'b1);
            end
        end
        // collect counter words by index
        if (lnk.out_valid && int'(lnk.out_idx) < NOUT) begin
            d.rx[int'(lnk.out_idx)*SBIN_WORD_W +: SBIN_WORD_W] = lnk.out_word;
            d.done = lnk.out_last;
        end
        // unpack one counter by channel and 1-based code
        d.cnt = '0;
        if (int'(sel_ch) < NUM_CH && sel_code != 3'h0 && int'(sel_code) <= CODES) begin
            off   = (int'(sel_ch) * CODES + int'(sel_code) - 1) * CNT_W;
            d.cnt = q.rx[off +: CNT_W];
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge lnk.core_clk) begin
        if (!lnk.rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign lnk.code_valid                   = q.cv;
    assign lnk.code_idx                     = q.cidx;
    assign lnk.code_word                    = q.cword;
    assign lnk.external_latch_trigger_input = q.trig;
    assign sel_count                        = q.cnt;
    assign frame_done                       = q.done;
endmodule

// [dv/sbin_monitor.sv]
// link checker for the bin counter and its partner end
// assumes default sizes (four words a frame) and one clock domain
`timescale 1ns/1ps
module sbin_monitor
    import sbin_pkg::*;
#(
    parameter int NUM_CH = SBIN_NUM_CH,
    parameter int CODES  = SBIN_CODES,
    parameter int CNT_W  = SBIN_CNT_W
) (
    // clock and reset
    input wire logic                   core_clk,
    input wire logic                   rst_n,
    // code stream
    input wire logic                   code_valid,
    input wire logic [SBIN_IDX_W-1:0]  code_idx,
    input wire logic [SBIN_WORD_W-1:0] code_word,
    input wire logic                   external_latch_trigger_input,
    // counter stream
    input wire logic                   out_valid,
    input wire logic [SBIN_IDX_W-1:0]  out_idx,
    input wire logic [SBIN_WORD_W-1:0] out_word,
    input wire logic                   out_last
);
    // ****
    // frame shape
    // ****
    localparam int NOUT = (NUM_CH * CODES * CNT_W + 31) / 32; // words a frame
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // one word of a frame before the closing word
    sequence s_word(int i);
        out_valid && out_idx == i && !out_last;
    endsequence
    // closing word; the chain below is written for four words only
    sequence s_tail;
        out_valid && out_idx == NOUT - 1 && out_last;
    endsequence

    // a lane may hold unsorted, a hardware sort class or the outlier code
    function automatic logic lane_ok(logic [7:0] c);
        return c <= 8'(SBIN_MAX_SORTS) || c == SBIN_CODE_OUTLIER;
    endfunction

    AST_FRAME_SEQ: assert property ($rose(out_valid) |->
        s_word(0) ##1 s_word(1) ##1 s_word(2) ##1 s_tail)
        else $error("frame words out of order");
    AST_LAST_IDX: assert property (out_valid && out_last |-> out_idx == NOUT - 1)
        else $error("last flag on wrong word");
    AST_LAST_VALID: assert property (out_last |-> out_valid)
        else $error("last flag without word");
    AST_CONT: assert property (out_valid && !out_last |=> out_valid)
        else $error("gap inside a frame");
    AST_TRIG: assert property ($rose(external_latch_trigger_input) |-> ##[1:5] s_word(0))
        else $error("trigger edge gave no frame");
    AST_CODE_GAP: assert property (code_valid |=> !code_valid [*3])
        else $error("code words closer than four channels");
    AST_CODE_IDX: assert property (code_valid |-> code_idx < NUM_CH / 4)
        else $error("code word index out of range");
    AST_LANE_CODES: assert property (code_valid |-> lane_ok(code_word[7:0])
        && lane_ok(code_word[15:8]) && lane_ok(code_word[23:16]) && lane_ok(code_word[31:24]))
        else $error("lane holds an illegal code");
endmodule

// [dv/tb.sv]
// self-checking bench: both ends joined over the link, user sides driven here
// assumes default channel, code and counter sizes and a shortened strobe timer
`timescale 1ns/1ps
module tb;
    import sbin_pkg::*;
    // ****
    // signals
    // ****
    localparam int TCYC = 20;           // short timer keeps the run brief
    logic        core_clk;
    logic        rst_n;
    logic [7:0]  usr_addr;
    logic [31:0] usr_wdata;
    logic        usr_wr;
    logic        usr_rd;
    logic [31:0] usr_rdata;
    logic        strobe_pulse;
    logic        ch_valid;
    logic [7:0]  ch_code;
    logic        ch_last;
    logic        trig_in;
    logic [7:0]  sel_ch;
    logic [2:0]  sel_code;
    logic [3:0]  sel_count;
    logic        frame_done;
    logic        rd_d;                  // read taken last edge
    logic [31:0] rng;                   // xorshift state
    logic [31:0] out_q[$];              // expected counter words
    logic [31:0] rd_q[$];               // expected read data
    logic [3:0]  cnt[16][2];            // running counts
    logic [3:0]  lat[16][2];            // counts of the frame in flight
    int          n_mismatch;
    int          samples_checked;
    int          n;

    // ****
    // the two ends and the checker
    // ****
    sbin_if u_sbin_if (.core_clk(core_clk), .rst_n(rst_n));
    sbin_binner #(.TIMER_CYCLES(TCYC)) u_sbin_binner (.lnk(u_sbin_if.binner),
        .usr_addr(usr_addr), .usr_wdata(usr_wdata), .usr_wr(usr_wr), .usr_rd(usr_rd),
        .usr_rdata(usr_rdata), .strobe_pulse(strobe_pulse));
    sbin_partner u_sbin_partner (.lnk(u_sbin_if.partner), .ch_valid(ch_valid),
        .ch_code(ch_code), .ch_last(ch_last), .trig_in(trig_in), .sel_ch(sel_ch),
        .sel_code(sel_code), .sel_count(sel_count), .frame_done(frame_done));
    sbin_monitor u_sbin_monitor (.core_clk(core_clk), .rst_n(rst_n),
        .code_valid(u_sbin_if.code_valid), .code_idx(u_sbin_if.code_idx),
        .code_word(u_sbin_if.code_word),
        .external_latch_trigger_input(u_sbin_if.external_latch_trigger_input),
        .out_valid(u_sbin_if.out_valid), .out_idx(u_sbin_if.out_idx),
        .out_word(u_sbin_if.out_word), .out_last(u_sbin_if.out_last));

    // ****
    // helpers
    // ****
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic check(logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // one-cycle write strobe
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge core_clk);
        usr_addr <= a;
        usr_wdata <= d;
        usr_wr <= 1'b1;
        @(posedge core_clk);
        usr_wr <= 1'b0;
    endtask

    // one-cycle read strobe; the watcher compares the data
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge core_clk);
        usr_addr <= a;
        usr_rd <= 1'b1;
        rd_q.push_back(e);
        @(posedge core_clk);
        usr_rd <= 1'b0;
    endtask

    // one channel a cycle, rounds of sixteen; mask picks the code mix
    task automatic feed(int rounds, logic [7:0] mask);
        logic [7:0] c;
        for (int r = 0; r < rounds; r++)
            for (int ch = 0; ch < 16; ch++) begin
                @(posedge core_clk);
                rng = xs(rng);
                c = rng[7:0] & mask;
                ch_valid <= 1'b1;
                ch_code <= c;
                ch_last <= (ch == 15);
                if ((c == 8'h01 || c == 8'h02) && cnt[ch][c-1] != 4'hF)
                    cnt[ch][c-1]++;
            end
        @(posedge core_clk);
        ch_valid <= 1'b0;
        ch_last <= 1'b0;
    endtask

    // trigger edge, note the frame, then read every counter back through the partner
    task automatic strobe_ext();
        logic [31:0] wd;
        int          i;
        repeat (4) @(posedge core_clk);
        for (int w = 0; w < 4; w++) begin
            for (int b = 0; b < 8; b++)
                wd[4*b +: 4] = cnt[4*w + b/2][b%2];
            out_q.push_back(wd);
        end
        lat = cnt;
        cnt = '{default: 4'h0};
        trig_in <= 1'b1;
        i = 0;
        while (frame_done !== 1'b1 && i < 30) begin
            @(negedge core_clk);
            i++;
        end
        @(posedge core_clk);
        trig_in <= 1'b0;
        check(32'(i < 30), 32'h1);
        for (int ch = 0; ch < 16; ch++)
            for (int c = 0; c < 2; c++) begin
                @(posedge core_clk);
                sel_ch <= 8'(ch);
                sel_code <= 3'(c + 1);
                @(posedge core_clk);
                @(negedge core_clk);
                check(32'(sel_count), 32'(lat[ch][c]));
            end
    endtask

    // negedge counts until the next strobe pulse
    task automatic wait_strobe(output int k);
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
        end while (strobe_pulse !== 1'b1 && k < 200);
    endtask

    // ****
    // clock, watcher, watchdog, main sequence
    // ****
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
        rd_d <= usr_rd;

    // sample mid-cycle so edge updates have landed
    always @(negedge core_clk) begin
        if (rd_d)
            check(usr_rdata, rd_q.pop_front());
        if (u_sbin_if.out_valid === 1'b1) begin
            // a word nobody announced is a mismatch of its own
            check(32'(out_q.size() > 0), 32'h1);
            if (out_q.size() > 0)
                check(u_sbin_if.out_word, out_q.pop_front());
        end
    end

    initial begin
        #200000;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        {usr_addr, usr_wdata, usr_wr, usr_rd, sel_ch, sel_code} = '0;
        {ch_valid, ch_code, ch_last, trig_in} = '0;
        rst_n = 1'b0;
        n_mismatch = 0;
        samples_checked = 0;
        rng = 32'hF6FF;
        cnt = '{default: 4'h0};
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        wr(SBIN_REG_CTRL, 32'h3);
        rd(SBIN_REG_CTRL, 32'h3);
        rd(8'h08, 32'h0);
        feed(8, 8'h07);
        strobe_ext();
        feed(80, 8'h03);
        strobe_ext();
        rd(SBIN_REG_STATUS, 32'h2);
        // two timer frames follow with nothing fed since the last strobe
        repeat (8) out_q.push_back(32'h0);
        wr(SBIN_REG_CTRL, 32'h2);
        wait_strobe(n);
        wait_strobe(n);
        check(32'(n), 32'(TCYC));
        repeat (8) @(posedge core_clk);
        // run bit off: no strobe at all, strobe count stays at four
        wr(SBIN_REG_CTRL, 32'h0);
        wait_strobe(n);
        check(32'(n), 32'hC8);
        rd(SBIN_REG_STATUS, 32'h4);
        repeat (2) @(posedge core_clk);
        print_verdict();
    end
endmodule
